// ---- core/otgr_consts.svh ----
// Constants for the OTG power control and rising-edge enable registers.
// Assumes a ULPI-style register port that presents 6-bit addresses.
`ifndef OTGR_CONSTS_SVH
`define OTGR_CONSTS_SVH
`define OTGR_OTG_WR_ADDR 6'h0A
`define OTGR_OTG_SET_ADDR 6'h0B
`define OTGR_OTG_CLR_ADDR 6'h0C
`define OTGR_RISE_WR_ADDR 6'h0D
`define OTGR_RISE_SET_ADDR 6'h0E
`define OTGR_RISE_CLR_ADDR 6'h0F
`define OTGR_OTG_RESET 8'h06
`define OTGR_RISE_RESET 8'h1F
`define OTGR_RISE_MASK 8'h1F
`define OTGR_BIT_EXT_IND 7
`define OTGR_BIT_EXT_SUPPLY 6
`define OTGR_BIT_DRIVE 5
`define OTGR_BIT_CHARGE 4
`define OTGR_BIT_DISCHARGE 3
`define OTGR_BIT_DM_PD 2
`define OTGR_BIT_DP_PD 1
`define OTGR_BIT_ID_PU 0
`endif

// ---- core/otgr_pkg.sv ----
// Types for the OTG power control register bank.
// Assumes otgr_consts.svh supplies the numeric layout.
`default_nettype none
package otgr_pkg;
	typedef struct packed {
		logic external_power_indicator_select;
		logic external_supply_select;
		logic power_output_drive;
		logic power_line_charge;
		logic power_line_discharge;
		logic minus_line_pulldown;
		logic plus_line_pulldown;
		logic cable_sample_a;
	} otgr_ctrl_t;
	typedef struct packed {
		logic cable_grounded;
		logic session_finished_flag;
		logic session_ok;
		logic power_ok;
		logic host_unplug;
	} otgr_status_t;
	typedef enum logic [1:0] {
		OTGR_OP_WRITE = 2'h0,
		OTGR_OP_SET = 2'h1,
		OTGR_OP_CLEAR = 2'h2,
		OTGR_OP_NONE = 2'h3
	} otgr_op_t;
endpackage
`default_nettype wire

// ---- core/otgr_rise_detect.sv ----
// Rising-edge event gate for the five status signals.
// Assumes status inputs are synchronous to clk_sys_in.
`timescale 1ns/1ns
`default_nettype none
module otgr_rise_detect (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire otgr_pkg::otgr_status_t status_in,
	input wire logic [4:0] enable_in,
	output logic [4:0] event_out
);
	logic [4:0] prev_r;
	logic [4:0] prev_nxt;
	logic [4:0] event_r;
	logic [4:0] event_nxt;

	always_comb begin
		prev_nxt = status_in;
		// Cleared enable swallows the edge [RULE_10]
		event_nxt = status_in & ~prev_r & enable_in;
	end

	// Previous value starts low so a high level after reset counts as a rise
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			prev_r <= 5'h00;
			event_r <= 5'h00;
		end else begin
			prev_r <= prev_nxt;
			event_r <= event_nxt;
		end
	end

	assign event_out = event_r;
endmodule // otgr_rise_detect
`default_nettype wire

// ---- core/otgr_regs.sv ----
// OTG power control and rising-edge enable register bank.
// Assumes a decoded ULPI register port: one-cycle write strobe with address and data,
// read address answered combinationally into a registered read data.
// Status and indicator inputs are taken as already synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
`include "otgr_consts.svh"

// Behaviour
// RULE_01 - Bit 7 picks the external fault pin instead of the internal comparator as power indication.
// RULE_02 - Bit 6 picks an external supply and then drives the supply switch output low.
// RULE_03 - Bit 5 drives 5 V onto the power line and resets to 0.
// RULE_04 - Bit 4 charges the power line through a resistor and resets to 0.
// RULE_05 - The link confirms discharge and 2 ms of SE0 before setting the charge bit.
// RULE_06 - Bit 3 discharges the power line, resets to 0, and the link clears it after session end rises.
// RULE_07 - Bit 2 connects the minus line pull-down and resets to 1.
// RULE_08 - Bit 1 connects the plus line pull-down and resets to 1.
// RULE_09 - Bit 0 connects the ID pull-up and enables ID sampling, resetting to 0.
// RULE_10 - Each rise enable bit lets a 0 to 1 status change raise an event, else it is suppressed.
// RULE_11 - Rise enable bits 4 to 0 reset to 1 and bits 7 to 5 read as 0.
// RULE_12 - Rise enables read at 0Dh to 0Fh, written at 0Dh, set at 0Eh, cleared at 0Fh.
// RULE_13 - Rise bits 4..0 cover ID ground, session end, session valid, power valid, host unplug.
// RULE_14 - Control reads at 0Ah to 0Ch, written at 0Ah, set at 0Bh, cleared at 0Ch.
// RULE_15 - Set addresses OR ones in, clear addresses clear ones, other bits stay.
module otgr_regs (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic [5:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [5:0] reg_raddr_in,
	input wire logic fault_pin_in,
	input wire logic power_comparator_in,
	input wire otgr_pkg::otgr_status_t status_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rhit_out,
	output otgr_pkg::otgr_ctrl_t ctrl_out,
	output logic supply_switch_out_low,
	output logic power_indication_out,
	output logic [4:0] rise_event_out
);
	// ***************************
	// Write decode
	// ***************************
	function automatic logic [7:0] apply_op(input logic [7:0] cur, input logic [7:0] wd,
			input otgr_pkg::otgr_op_t op);
		logic [7:0] res;
		res = cur;
		unique case (op)
			otgr_pkg::OTGR_OP_WRITE: res = wd;
			otgr_pkg::OTGR_OP_SET: res = cur | wd; // [RULE_15]
			otgr_pkg::OTGR_OP_CLEAR: res = cur & ~wd; // [RULE_15]
			otgr_pkg::OTGR_OP_NONE: res = cur;
		endcase
		return res;
	endfunction

	function automatic otgr_pkg::otgr_op_t decode_op(input logic wr, input logic [5:0] a,
			input logic [5:0] base);
		otgr_pkg::otgr_op_t op;
		op = otgr_pkg::OTGR_OP_NONE;
		if (wr && a == base) begin
			op = otgr_pkg::OTGR_OP_WRITE;
		end else if (wr && a == base + 6'h01) begin
			op = otgr_pkg::OTGR_OP_SET;
		end else if (wr && a == base + 6'h02) begin
			op = otgr_pkg::OTGR_OP_CLEAR;
		end
		return op;
	endfunction

	function automatic logic in_window(input logic [5:0] a, input logic [5:0] base);
		return a >= base && a <= base + 6'h02;
	endfunction

	// ***************************
	// Write opcodes
	// ***************************
	otgr_pkg::otgr_op_t otg_op;
	otgr_pkg::otgr_op_t rise_op;

	// Each register owns three addresses: write, set and clear [RULE_12] [RULE_14]
	always_comb begin
		otg_op = decode_op(reg_wr_in, reg_addr_in, `OTGR_OTG_WR_ADDR);
		rise_op = decode_op(reg_wr_in, reg_addr_in, `OTGR_RISE_WR_ADDR);
	end

	// ***************************
	// Power control register
	// ***************************
	logic [7:0] otg_power_control_r;
	logic [7:0] otg_power_control_nxt;

	always_comb begin
		otg_power_control_nxt = apply_op(otg_power_control_r, reg_wdata_in, otg_op); // [RULE_14]
	end

	// Pull-downs start connected, drive, charge, discharge and ID pull-up start off [RULE_07] [RULE_08]
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			otg_power_control_r <= `OTGR_OTG_RESET; // [RULE_03] [RULE_04] [RULE_06] [RULE_09]
		end else begin
			otg_power_control_r <= otg_power_control_nxt;
		end
	end

	// ***************************
	// Rising-edge enable register
	// ***************************
	logic [7:0] rise_event_enable_r;
	logic [7:0] rise_event_enable_nxt;

	// Reserved bits forced low so they always read as zero [RULE_11]
	always_comb begin
		rise_event_enable_nxt = apply_op(rise_event_enable_r, reg_wdata_in, rise_op)
			& `OTGR_RISE_MASK; // [RULE_12]
	end

	// All five edges start enabled
	// Bits 4..0 line up with the status struct, most significant first [RULE_13]
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rise_event_enable_r <= `OTGR_RISE_RESET; // [RULE_11]
		end else begin
			rise_event_enable_r <= rise_event_enable_nxt;
		end
	end

	// ***************************
	// Supply switch
	// ***************************
	otgr_pkg::otgr_ctrl_t ctrl_cur;
	logic psw_low_r;
	logic psw_low_nxt;

	// Taken from the next register value so the pin moves on the same edge as the bit
	always_comb begin
		ctrl_cur = otg_power_control_nxt;
		// Switch goes low only for the external supply [RULE_02]
		psw_low_nxt = ctrl_cur.external_supply_select;
	end

	// Released after reset, so the internal pump is the default
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			psw_low_r <= 1'b0; // [RULE_02]
		end else begin
			psw_low_r <= psw_low_nxt;
		end
	end

	// ***************************
	// Power indication
	// ***************************
	logic ind_r;
	logic ind_nxt;

	// One cycle of latency from either source; both are taken as already synchronous
	always_comb begin
		// Source of power indication [RULE_01]
		ind_nxt = ctrl_cur.external_power_indicator_select ? fault_pin_in : power_comparator_in;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ind_r <= 1'b0;
		end else begin
			ind_r <= ind_nxt;
		end
	end

	// ***************************
	// Read path
	// ***************************
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rhit_r;
	logic rhit_nxt;

	// Any of the three addresses of a register reads it back
	always_comb begin
		rdata_nxt = 8'h00;
		rhit_nxt = 1'b0;
		if (in_window(reg_raddr_in, `OTGR_OTG_WR_ADDR)) begin
			rdata_nxt = otg_power_control_r; // [RULE_14]
			rhit_nxt = 1'b1;
		end else if (in_window(reg_raddr_in, `OTGR_RISE_WR_ADDR)) begin
			rdata_nxt = rise_event_enable_r; // [RULE_12]
			rhit_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_r <= 8'h00;
			rhit_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rhit_r <= rhit_nxt;
		end
	end

	// ***************************
	// Outputs
	// ***************************
	// Bits drive analog controls straight from the flops [RULE_03] [RULE_04] [RULE_06]
	assign ctrl_out = otg_power_control_r;
	assign supply_switch_out_low = psw_low_r;
	assign power_indication_out = ind_r;
	assign reg_rdata_out = rdata_r;
	assign reg_rhit_out = rhit_r;

	// Bit order follows the status struct [RULE_13]
	otgr_rise_detect otgr_rise_detect_i (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.status_in(status_in),
		.enable_in(rise_event_enable_r[4:0]),
		.event_out(rise_event_out)
	);
endmodule // otgr_regs
`default_nettype wire

// ---- testbench/otgr_regs_sva.sv ----
// Port checker for otgr_regs.
// Bound to every otgr_regs; synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module otgr_regs_sva (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic [5:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [5:0] reg_raddr_in,
	input wire otgr_pkg::otgr_status_t status_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rhit_out,
	input wire otgr_pkg::otgr_ctrl_t ctrl_out,
	input wire logic supply_switch_out_low,
	input wire logic [4:0] rise_event_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	sequence wr_at(logic [5:0] a); reg_wr_in && reg_addr_in == a; endsequence
	ctrl_write_a: assert property (wr_at(6'h0A) |=> ctrl_out == $past(reg_wdata_in))
		else $error("write lost");
	ctrl_set_a: assert property (wr_at(6'h0B) |=>
		ctrl_out == ($past(ctrl_out) | $past(reg_wdata_in))) else $error("set wrong");
	ctrl_clear_a: assert property (wr_at(6'h0C) |=>
		ctrl_out == ($past(ctrl_out) & ~$past(reg_wdata_in))) else $error("clear wrong");
	ctrl_keep_a: assert property (!(reg_wr_in && reg_addr_in inside {[6'h0A:6'h0C]}) |=>
		$stable(ctrl_out)) else $error("control moved");
	switch_low_a: assert property (supply_switch_out_low == ctrl_out[6])
		else $error("switch wrong");
	rise_read_a: assert property (reg_raddr_in inside {[6'h0D:6'h0F]} |=>
		reg_rhit_out && reg_rdata_out[7:5] == 3'h0) else $error("rise read");
	miss_read_a: assert property (!(reg_raddr_in inside {[6'h0A:6'h0F]}) |=>
		!reg_rhit_out && reg_rdata_out == 8'h00) else $error("miss read");
	event_cause_a: assert property ((rise_event_out & ~$past(status_in)) == 5'h00)
		else $error("event without status");
	event_single_a: assert property ((rise_event_out & $past(rise_event_out)) == 5'h00)
		else $error("event longer than one cycle");
endmodule // otgr_regs_sva
bind otgr_regs otgr_regs_sva otgr_regs_sva_i (.*);
`default_nettype wire

// ---- testbench/otgr_link_model.sv ----
// Link side: issues register writes as one-cycle strobes.
// The bench calls send; one write per call.
`timescale 1ns/1ns
`default_nettype none
module otgr_link_model (
	input wire logic clk_sys_in,
	output logic wr_out,
	output logic [5:0] addr_out,
	output logic [7:0] data_out
);
	initial begin
		wr_out = 1'b0;
		addr_out = 6'h00;
		data_out = 8'h00;
	end
	// Discharge before charge is not checked; SE0 timing is not modelled
	task automatic send(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		#1;
		wr_out = 1'b1;
		addr_out = a;
		data_out = d;
		@(posedge clk_sys_in);
		#1;
		wr_out = 1'b0;
		data_out = ~d; // Released data must not look valid
	endtask
endmodule // otgr_link_model
`default_nettype wire

// ---- testbench/otg_power_control_and_rise_irq_enable_bench.sv ----
// Self-checking bench for otgr_regs.
// Writes come from otgr_link_model; reads, status and pins from here.
`timescale 1ns/1ns
`default_nettype none
module otg_power_control_and_rise_irq_enable_bench;
	typedef struct packed {logic [5:0] a; logic [7:0] d; logic [5:0] r; logic [7:0] x;} otgr_row_t;
	logic clk_sys_in = 0, rst_in = 1, fp = 0, pc = 0, wr, hit, swl, ind;
	logic [5:0] ra = 6'h00, wa;
	logic [7:0] wd, rd;
	logic [4:0] ev;
	otgr_pkg::otgr_status_t st = 5'h00;
	otgr_pkg::otgr_ctrl_t ctrl;
	int num_errors = 0, num_checks = 0;
	otgr_row_t rows [8] = '{'{6'h0A, 8'hFF, 6'h0C, 8'hFF}, '{6'h0C, 8'h81, 6'h0B, 8'h7E},
		'{6'h0B, 8'h01, 6'h0A, 8'h7F}, '{6'h0A, 8'h00, 6'h0A, 8'h00}, '{6'h0D, 8'hFF, 6'h0F, 8'h1F},
		'{6'h0F, 8'h05, 6'h0D, 8'h1A}, '{6'h0E, 8'h24, 6'h0E, 8'h1E}, '{6'h0D, 8'h00, 6'h0D, 8'h00}};
	otgr_regs otgr_regs_i (.clk_sys_in, .rst_in, .reg_wr_in(wr), .reg_addr_in(wa),
		.reg_wdata_in(wd), .reg_raddr_in(ra), .fault_pin_in(fp), .power_comparator_in(pc),
		.status_in(st), .reg_rdata_out(rd), .reg_rhit_out(hit), .ctrl_out(ctrl),
		.supply_switch_out_low(swl), .power_indication_out(ind), .rise_event_out(ev));
	otgr_link_model otgr_link_model_i (.clk_sys_in, .wr_out(wr), .addr_out(wa), .data_out(wd));
	always #5 clk_sys_in = ~clk_sys_in;
	task chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task tick;
		@(posedge clk_sys_in);
		#1;
	endtask
	task rdc(input logic [5:0] a, input logic [7:0] e);
		ra = a;
		tick;
		chk(rd, e);
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		test_done;
	end
	initial begin
		repeat (3) tick;
		rst_in = 0;
		chk(ctrl, 8'h06);
		rdc(6'h0E, 8'h1F);
		chk({7'h00, hit}, 8'h01);
		rdc(6'h09, 8'h00);
		chk({7'h00, hit}, 8'h00);
		foreach (rows[i]) begin
			otgr_link_model_i.send(rows[i].a, rows[i].d);
			rdc(rows[i].r, rows[i].x);
		end
		otgr_link_model_i.send(6'h0A, 8'hC0);
		fp = 1;
		tick;
		chk({6'h00, swl, ind}, 8'h03);
		otgr_link_model_i.send(6'h0A, 8'h00);
		fp = 0;
		pc = 1;
		tick;
		chk({6'h00, swl, ind}, 8'h01);
		// Every status bit rises at once; only the enabled one may report
		for (int b = 0; b < 5; b++) begin
			st = 5'h00;
			otgr_link_model_i.send(6'h0D, 8'h01 << b);
			st = 5'h1F;
			tick;
			chk({3'h0, ev}, 8'h01 << b);
			tick;
			chk({3'h0, ev}, 8'h00);
		end
		// Discharge, wait for the session end event, stop, then pulse the charge
		st = 5'h00;
		otgr_link_model_i.send(6'h0E, 8'h08);
		otgr_link_model_i.send(6'h0B, 8'h08);
		chk(ctrl, 8'h08);
		st = 5'h08;
		tick;
		chk({3'h0, ev}, 8'h08);
		otgr_link_model_i.send(6'h0C, 8'h08);
		chk(ctrl, 8'h00);
		otgr_link_model_i.send(6'h0B, 8'h10);
		chk(ctrl, 8'h10);
		rst_in = 1;
		tick;
		rst_in = 0;
		rdc(6'h0F, 8'h1F);
		chk(ctrl, 8'h06);
		// Status already high when reset lets go reports once, enables are back at one
		chk({3'h0, ev}, 8'h08);
		test_done;
	end
endmodule // otg_power_control_and_rise_irq_enable_bench
`default_nettype wire
